// [rtl/overlay_cursor_config_regs.sv]
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/1ps
module overlay_cursor_config_regs
    import ovl_cfg_pkg::*;
(
    input  wire logic [ADDR_W-1:0]  address,
    input  wire logic                clock,
    input  wire logic                rst_n,
    input  wire logic                read,
    input  wire logic                write,
    input  wire logic [DATA_W-1:0]  writedata,
    input  wire logic [BE_W-1:0]    byteenable,
    output logic      [DATA_W-1:0]  readdata,
    output logic                     waitrequest,
    input  wire logic                overlay_select,
    input  wire logic                vertical_scan_reverse,
    input  wire logic                frame_start,
    input  wire logic [SCALE_W-1:0] char_scale_x,
    input  wire logic [SCALE_W-1:0] char_scale_y,
    input  wire logic                gamma_wr,
    input  wire logic [7:0]          gamma_wr_addr,
    input  wire logic [7:0]          gamma_wr_data,
    input  wire rgb_t                pixel_in,
    input  wire logic                pixel_in_valid,
    output rgb_t                     pixel_out,
    output logic                     pixel_out_valid,
    output overlay_geom_t            overlay1,
    output overlay_geom_t            overlay2,
    output logic                     gamma_enable,
    output logic                     graphic_cursor_on,
    output logic [1:0]               cursor_shape_set,
    output logic                     text_cursor_on,
    output logic [POS_W-1:0]         graphic_cursor_x,
    output logic [POS_W-1:0]         graphic_cursor_y,
    output color332_t                cursor_color_a,
    output color332_t                cursor_color_b,
    output logic [TCPX_W-1:0]        text_cursor_w_px,
    output logic [TCPX_W-1:0]        text_cursor_h_px
);

    function automatic logic [15:0] join_bytes(
        input logic [7:0] hi,
        input logic [7:0] lo,
        input logic [7:0] hm,
        input logic [7:0] lm
    );
        return {hi & hm, lo & lm};
    endfunction

    function automatic logic [TCPX_W-1:0] scale(
        input logic [CUR_W-1:0]   s,
        input logic [SCALE_W-1:0] f
    );
        logic [TCPX_W-1:0] a;
        logic [TCPX_W-1:0] b;
        a = TCPX_W'(s) + ONE8;
        b = TCPX_W'(f) + ONE8;
        return TCPX_W'(a * b);
    endfunction

    bus_state_t          bus_q;
    logic                wait_q;
    logic [DATA_W-1:0]   rdata_q;
    logic [IDX_W-1:0]    idx;
    logic [7:0]          wbyte;
    logic                wr_fire;
    logic [7:0]          rd_byte;
    overlay_geom_t       ovl1_q;
    overlay_geom_t       ovl2_q;
    overlay_geom_t       sel_geom;
    logic [7:0]          lo_topy_q;
    logic [7:0]          lo_wid_q;
    logic [7:0]          lo_hgt_q;
    logic [15:0]         topy_new;
    logic [15:0]         wid_new;
    logic [15:0]         hgt_new;
    logic [7:0]          ctl_q;
    logic [7:0]          blink_period_q;
    logic [CUR_W-1:0]    tcw_q;
    logic [CUR_W-1:0]    tch_q;
    logic [POS_W-1:0]    gcx_q;
    logic [POS_W-1:0]    gcy_q;
    logic [7:0]          cola_q;
    logic [7:0]          colb_q;
    logic [7:0]          blink_cnt_q;
    logic                phase_q;
    logic                gc_eff;
    logic                gc_on_q;
    logic                tc_on_q;
    logic [1:0]          shape_q;
    logic [TCPX_W-1:0]   tcw_px_q;
    logic [TCPX_W-1:0]   tch_px_q;
    rgb_t                pix_q;
    logic                pix_vld_q;
    logic [7:0]          gam_r [GAM_D];
    logic [7:0]          gam_g [GAM_D];
    logic [7:0]          gam_b [GAM_D];

    assign idx      = address[ADDR_W-1:ADDR_LSB];
    assign wbyte    = writedata[BYTE_W-1:0];
    assign wr_fire  = (bus_q == BUS_ACK) && write && byteenable[0];
    assign sel_geom = overlay_select ? ovl2_q : ovl1_q;
    assign gc_eff   = ctl_q[CTL_GC_EN] && !vertical_scan_reverse;

    // low bits cleared so stored geometry is always on its grid
    assign topy_new = join_bytes(wbyte, lo_topy_q, HI13_MASK, LO_V_MASK);
    assign wid_new  = join_bytes(wbyte, lo_wid_q, HI14_MASK, LO_H_MASK);
    assign hgt_new  = join_bytes(wbyte, lo_hgt_q, HI14_MASK, LO_V_MASK);

    // avalon slave: one wait cycle, answer in the second
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            bus_q <= BUS_IDLE;
        end
        else
        begin
            case (bus_q)
                BUS_IDLE:
                begin
                    if (read || write)
                    begin
                        bus_q <= BUS_ACK;
                    end
                end
                BUS_ACK:
                begin
                    bus_q <= BUS_IDLE;
                end
                default:
                begin
                    bus_q <= BUS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            wait_q <= 1'b1;
        end
        else
        begin
            wait_q <= !((bus_q == BUS_IDLE) && (read || write));
        end
    end

    always_comb
    begin
        rd_byte = '0;
        case (idx)
            IDX_TOPY_LO: rd_byte = sel_geom.top_y[7:0];
            IDX_TOPY_HI: rd_byte = BYTE_W'(sel_geom.top_y[POS_W-1:8]);
            IDX_WID_LO:  rd_byte = sel_geom.width[7:0];
            IDX_WID_HI:  rd_byte = BYTE_W'(sel_geom.width[SIZE_W-1:8]);
            IDX_HGT_LO:  rd_byte = sel_geom.height[7:0];
            IDX_HGT_HI:  rd_byte = BYTE_W'(sel_geom.height[SIZE_W-1:8]);
            IDX_CTL:     rd_byte = ctl_q;
            IDX_BLINK:   rd_byte = blink_period_q;
            IDX_TCW:     rd_byte = BYTE_W'(tcw_q);
            IDX_TCH:     rd_byte = BYTE_W'(tch_q);
            IDX_GCX_LO:  rd_byte = gcx_q[7:0];
            IDX_GCX_HI:  rd_byte = BYTE_W'(gcx_q[POS_W-1:8]);
            IDX_GCY_LO:  rd_byte = gcy_q[7:0];
            IDX_GCY_HI:  rd_byte = BYTE_W'(gcy_q[POS_W-1:8]);
            IDX_COLA:    rd_byte = cola_q;
            IDX_COLB:    rd_byte = colb_q;
            default:     rd_byte = '0;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            rdata_q <= '0;
        end
        else if ((bus_q == BUS_IDLE) && read)
        begin
            rdata_q <= DATA_W'(rd_byte);
        end
    end

    // low bytes wait in shadow storage until the high byte arrives
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            lo_topy_q <= '0;
            lo_wid_q  <= '0;
            lo_hgt_q  <= '0;
        end
        else if (wr_fire)
        begin
            case (idx)
                IDX_TOPY_LO: lo_topy_q <= wbyte;
                IDX_WID_LO:  lo_wid_q  <= wbyte;
                IDX_HGT_LO:  lo_hgt_q  <= wbyte;
                default:     lo_topy_q <= lo_topy_q;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            ovl1_q <= '0;
            ovl2_q <= '0;
        end
        else if (wr_fire)
        begin
            case (idx)
                IDX_TOPY_HI:
                begin
                    if (overlay_select)
                        ovl2_q.top_y <= topy_new[POS_W-1:0];
                    else
                        ovl1_q.top_y <= topy_new[POS_W-1:0];
                end
                IDX_WID_HI:
                begin
                    if (overlay_select)
                        ovl2_q.width <= wid_new[SIZE_W-1:0];
                    else
                        ovl1_q.width <= wid_new[SIZE_W-1:0];
                end
                IDX_HGT_HI:
                begin
                    if (overlay_select)
                        ovl2_q.height <= hgt_new[SIZE_W-1:0];
                    else
                        ovl1_q.height <= hgt_new[SIZE_W-1:0];
                end
                default:
                begin
                    ovl1_q <= ovl1_q;
                end
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            ctl_q          <= '0;
            blink_period_q <= '0;
            tcw_q          <= TCW_RST;
            tch_q          <= '0;
            cola_q         <= '0;
            colb_q         <= '0;
        end
        else if (wr_fire)
        begin
            case (idx)
                IDX_CTL:   ctl_q          <= wbyte;
                IDX_BLINK: blink_period_q <= wbyte;
                IDX_TCW:   tcw_q          <= wbyte[CUR_W-1:0];
                IDX_TCH:   tch_q          <= wbyte[CUR_W-1:0];
                IDX_COLA:  cola_q         <= wbyte;
                IDX_COLB:  colb_q         <= wbyte;
                default:   ctl_q          <= ctl_q;
            endcase
        end
    end

    // cursor position is taken byte by byte
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            gcx_q <= '0;
            gcy_q <= '0;
        end
        else if (wr_fire)
        begin
            case (idx)
                IDX_GCX_LO: gcx_q[7:0]       <= wbyte;
                IDX_GCX_HI: gcx_q[POS_W-1:8] <= wbyte[POS_W-9:0];
                IDX_GCY_LO: gcy_q[7:0]       <= wbyte;
                IDX_GCY_HI: gcy_q[POS_W-1:8] <= wbyte[POS_W-9:0];
                default:    gcx_q            <= gcx_q;
            endcase
        end
    end

    // blink phase flips after period plus one frame starts
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            blink_cnt_q <= '0;
            phase_q     <= 1'b1;
        end
        else if (!ctl_q[CTL_BLINK])
        begin
            blink_cnt_q <= '0;
            phase_q     <= 1'b1;
        end
        else if (frame_start)
        begin
            if (blink_cnt_q == blink_period_q)
            begin
                blink_cnt_q <= '0;
                phase_q     <= !phase_q;
            end
            else
            begin
                blink_cnt_q <= blink_cnt_q + ONE8;
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            gc_on_q  <= 1'b0;
            tc_on_q  <= 1'b0;
            shape_q  <= '0;
            tcw_px_q <= ONE8;
            tch_px_q <= ONE8;
        end
        else
        begin
            gc_on_q  <= gc_eff;
            tc_on_q  <= ctl_q[CTL_TC_EN] && !gc_eff && phase_q;
            shape_q  <= ctl_q[CTL_SH_HI:CTL_SH_LO];
            tcw_px_q <= scale(tcw_q, char_scale_x);
            tch_px_q <= scale(tch_q, char_scale_y);
        end
    end

    always_ff @(posedge clock)
    begin
        if (gamma_wr)
        begin
            case (ctl_q[CTL_TAB_HI:CTL_TAB_LO])
                TAB_BLUE:  gam_b[gamma_wr_addr] <= gamma_wr_data;
                TAB_GREEN: gam_g[gamma_wr_addr] <= gamma_wr_data;
                TAB_RED:   gam_r[gamma_wr_addr] <= gamma_wr_data;
                default:   ;
            endcase
        end
    end

    // gamma is the last stage before the panel
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            pix_q     <= '0;
            pix_vld_q <= 1'b0;
        end
        else
        begin
            pix_vld_q <= pixel_in_valid;
            if (pixel_in_valid && ctl_q[CTL_GAMMA])
                pix_q <= {gam_r[pixel_in.red], gam_g[pixel_in.green], gam_b[pixel_in.blue]};
            else if (pixel_in_valid)
                pix_q <= pixel_in;
        end
    end

    assign readdata          = rdata_q;
    assign waitrequest       = wait_q;
    assign overlay1          = ovl1_q;
    assign overlay2          = ovl2_q;
    assign gamma_enable      = ctl_q[CTL_GAMMA];
    assign graphic_cursor_on = gc_on_q;
    assign cursor_shape_set  = shape_q;
    assign text_cursor_on    = tc_on_q;
    assign graphic_cursor_x  = gcx_q;
    assign graphic_cursor_y  = gcy_q;
    assign cursor_color_a    = cola_q;
    assign cursor_color_b    = colb_q;
    assign text_cursor_w_px  = tcw_px_q;
    assign text_cursor_h_px  = tch_px_q;
    assign pixel_out         = pix_q;
    assign pixel_out_valid   = pix_vld_q;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    property p_topy_grid;
        ovl1_q.top_y[1:0] == 2'h0 && ovl2_q.top_y[1:0] == 2'h0;
    endproperty
    a_topy_grid: assert property (p_topy_grid)
        else $error("top y low bits not zero");

    property p_width_grid;
        ovl1_q.width[2:0] == 3'h0 && ovl2_q.width[2:0] == 3'h0;
    endproperty
    a_width_grid: assert property (p_width_grid)
        else $error("width off the eight pixel grid");

    property p_height_grid;
        ovl1_q.height[1:0] == 2'h0 && ovl2_q.height[1:0] == 2'h0;
    endproperty
    a_height_grid: assert property (p_height_grid)
        else $error("height low bits not zero");

    property p_commit_msb;
        $changed(ovl1_q.width) |->
            $past(wr_fire && idx == IDX_WID_HI && !overlay_select);
    endproperty
    a_commit_msb: assert property (p_commit_msb)
        else $error("width changed without high byte write");

    property p_lsb_held;
        wr_fire && idx == IDX_WID_LO |=> $stable(ovl1_q.width) && $stable(ovl2_q.width);
    endproperty
    a_lsb_held: assert property (p_lsb_held)
        else $error("low byte write changed width");

    property p_scan_rev_off;
        vertical_scan_reverse |=> !graphic_cursor_on;
    endproperty
    a_scan_rev_off: assert property (p_scan_rev_off)
        else $error("graphic cursor on while scan reversed");

    property p_graphic_wins;
        graphic_cursor_on |-> !text_cursor_on;
    endproperty
    a_graphic_wins: assert property (p_graphic_wins)
        else $error("both cursors shown");

    property p_no_blink_steady;
        !ctl_q[CTL_BLINK] && ctl_q[CTL_TC_EN] && !gc_eff && !phase_q |=> ##1 text_cursor_on;
    endproperty
    a_no_blink_steady: assert property (p_no_blink_steady)
        else $error("text cursor not steady without blink");

    property p_blink_flip;
        ctl_q[CTL_BLINK] && frame_start && blink_cnt_q == blink_period_q
            |=> blink_cnt_q == 8'h00 && phase_q != $past(phase_q);
    endproperty
    a_blink_flip: assert property (p_blink_flip)
        else $error("blink phase did not flip at period end");

    property p_width_scale;
        $past(rst_n) |-> text_cursor_w_px == scale($past(tcw_q), $past(char_scale_x));
    endproperty
    a_width_scale: assert property (p_width_scale)
        else $error("text cursor width not scaled");

    property p_gamma_bypass;
        pixel_in_valid && !ctl_q[CTL_GAMMA] |=> pixel_out_valid && pixel_out == $past(pixel_in);
    endproperty
    a_gamma_bypass: assert property (p_gamma_bypass)
        else $error("pixel altered with gamma off");

    property p_answer_soon;
        (read || write) && waitrequest && bus_q == BUS_IDLE |=> !waitrequest ##1 waitrequest;
    endproperty
    a_answer_soon: assert property (p_answer_soon)
        else $error("bus answer not in one cycle");

    property p_upper_zero;
        !waitrequest && read |-> readdata[DATA_W-1:BYTE_W] == '0;
    endproperty
    a_upper_zero: assert property (p_upper_zero)
        else $error("upper read bits not zero");

    c_commit_win2: cover property (wr_fire && idx == IDX_WID_HI && overlay_select);
    c_blink_flip:  cover property (ctl_q[CTL_BLINK] && $changed(phase_q));
    c_gamma_pix:   cover property (pixel_out_valid && gamma_enable);
    c_both_en:     cover property (ctl_q[CTL_TC_EN] && graphic_cursor_on);

endmodule // overlay_cursor_config_regs

// [rtl/ovl_cfg_pkg.sv]
package ovl_cfg_pkg;
    localparam int unsigned ADDR_W   = 10;
    localparam int unsigned ADDR_LSB = 2;
    localparam int unsigned DATA_W   = 32;
    localparam int unsigned BE_W     = 4;
    localparam int unsigned IDX_W    = 8;
    localparam int unsigned BYTE_W   = 8;
    localparam int unsigned POS_W    = 13;
    localparam int unsigned SIZE_W   = 14;
    localparam int unsigned CUR_W    = 5;
    localparam int unsigned SCALE_W  = 2;
    localparam int unsigned TCPX_W   = 8;
    localparam int unsigned GAM_D    = 256;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_TOPY_LO = 8'h36;
    localparam logic [7:0] IDX_TOPY_HI = 8'h37;
    localparam logic [7:0] IDX_WID_LO  = 8'h38;
    localparam logic [7:0] IDX_WID_HI  = 8'h39;
    localparam logic [7:0] IDX_HGT_LO  = 8'h3A;
    localparam logic [7:0] IDX_HGT_HI  = 8'h3B;
    localparam logic [7:0] IDX_CTL     = 8'h3C;
    localparam logic [7:0] IDX_BLINK   = 8'h3D;
    localparam logic [7:0] IDX_TCW     = 8'h3E;
    localparam logic [7:0] IDX_TCH     = 8'h3F;
    localparam logic [7:0] IDX_GCX_LO  = 8'h40;
    localparam logic [7:0] IDX_GCX_HI  = 8'h41;
    localparam logic [7:0] IDX_GCY_LO  = 8'h42;
    localparam logic [7:0] IDX_GCY_HI  = 8'h43;
    localparam logic [7:0] IDX_COLA    = 8'h44;
    localparam logic [7:0] IDX_COLB    = 8'h45;
    // field masks
    localparam logic [7:0] HI13_MASK = 8'h1F;
    localparam logic [7:0] HI14_MASK = 8'h3F;
    localparam logic [7:0] LO_V_MASK = 8'hFC;
    localparam logic [7:0] LO_H_MASK = 8'hF8;
    localparam logic [7:0] ALL_MASK  = 8'hFF;
    // control bit positions
    localparam int unsigned CTL_GAMMA  = 7;
    localparam int unsigned CTL_TAB_HI = 6;
    localparam int unsigned CTL_TAB_LO = 5;
    localparam int unsigned CTL_GC_EN  = 4;
    localparam int unsigned CTL_SH_HI  = 3;
    localparam int unsigned CTL_SH_LO  = 2;
    localparam int unsigned CTL_TC_EN  = 1;
    localparam int unsigned CTL_BLINK  = 0;
    localparam logic [1:0] TAB_BLUE  = 2'h0;
    localparam logic [1:0] TAB_GREEN = 2'h1;
    localparam logic [1:0] TAB_RED   = 2'h2;
    localparam logic [CUR_W-1:0]  TCW_RST = 5'h07;
    localparam logic [TCPX_W-1:0] ONE8    = 8'h01;
    typedef struct packed {
        logic [POS_W-1:0]  top_y;
        logic [SIZE_W-1:0] width;
        logic [SIZE_W-1:0] height;
    } overlay_geom_t;
    typedef struct packed {
        logic [2:0] red;
        logic [2:0] green;
        logic [1:0] blue;
    } color332_t;
    typedef struct packed {
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] blue;
    } rgb_t;
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK  = 2'b10
    } bus_state_t;
endpackage

// [tb/tb_overlay_cursor_config_regs.sv]
`timescale 1ns/1ps
module tb_overlay_cursor_config_regs
    import ovl_cfg_pkg::*;
;
    logic                clock;
    logic                rst_n = 1'b0;
    logic [ADDR_W-1:0]   address = 10'h000;
    logic                read = 1'b0;
    logic                write = 1'b0;
    logic [DATA_W-1:0]   writedata = 32'h00000000;
    logic [BE_W-1:0]     byteenable = 4'hF;
    logic [DATA_W-1:0]   readdata;
    logic                waitrequest;
    logic                overlay_select = 1'b0;
    logic                vertical_scan_reverse = 1'b0;
    logic                frame_start = 1'b0;
    logic [SCALE_W-1:0]  char_scale_x = 2'h0;
    logic [SCALE_W-1:0]  char_scale_y = 2'h0;
    logic                gamma_wr = 1'b0;
    logic [7:0]          gamma_wr_addr = 8'h00;
    logic [7:0]          gamma_wr_data = 8'h00;
    rgb_t                pixel_in = 24'h000000;
    logic                pixel_in_valid = 1'b0;
    rgb_t                pixel_out;
    logic                pixel_out_valid;
    overlay_geom_t       overlay1;
    overlay_geom_t       overlay2;
    logic                gamma_enable;
    logic                graphic_cursor_on;
    logic [1:0]          cursor_shape_set;
    logic                text_cursor_on;
    logic [POS_W-1:0]    graphic_cursor_x;
    logic [POS_W-1:0]    graphic_cursor_y;
    color332_t           cursor_color_a;
    color332_t           cursor_color_b;
    logic [TCPX_W-1:0]   text_cursor_w_px;
    logic [TCPX_W-1:0]   text_cursor_h_px;
    int                  failures = 0;
    int                  checked = 0;

    overlay_cursor_config_regs i_overlay_cursor_config_regs (
        .address(address), .clock(clock), .rst_n(rst_n), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .overlay_select(overlay_select),
        .vertical_scan_reverse(vertical_scan_reverse), .frame_start(frame_start),
        .char_scale_x(char_scale_x), .char_scale_y(char_scale_y), .gamma_wr(gamma_wr),
        .gamma_wr_addr(gamma_wr_addr), .gamma_wr_data(gamma_wr_data), .pixel_in(pixel_in),
        .pixel_in_valid(pixel_in_valid), .pixel_out(pixel_out),
        .pixel_out_valid(pixel_out_valid), .overlay1(overlay1), .overlay2(overlay2),
        .gamma_enable(gamma_enable), .graphic_cursor_on(graphic_cursor_on),
        .cursor_shape_set(cursor_shape_set), .text_cursor_on(text_cursor_on),
        .graphic_cursor_x(graphic_cursor_x), .graphic_cursor_y(graphic_cursor_y),
        .cursor_color_a(cursor_color_a), .cursor_color_b(cursor_color_b),
        .text_cursor_w_px(text_cursor_w_px), .text_cursor_h_px(text_cursor_h_px)
    );

    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e)
        begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic close_out;
        $display("checks %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // one transfer; request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic we, input logic [7:0] i, input logic [7:0] d,
                       output logic [31:0] q);
        int n;
        @(posedge clock);
        address   <= {i, 2'h0};
        writedata <= {24'h000000, d};
        write     <= we;
        read      <= ~we;
        n = 0;
        do @(posedge clock); while (waitrequest !== 1'b0 && ++n < 20);
        q = readdata;
        if (n >= 20) chk(32'h00000000, 32'h00000001);
        write <= 1'b0;
        read  <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, i, d, q);
    endtask

    task automatic rd(input logic [7:0] i, input logic [7:0] e);
        logic [31:0] q;
        bus(1'b0, i, 8'h00, q);
        chk(q, {24'h000000, e});
    endtask

    task automatic nap;
        repeat (2) @(negedge clock);
    endtask

    task automatic frame;
        @(posedge clock);
        frame_start <= 1'b1;
        @(posedge clock);
        frame_start <= 1'b0;
        nap;
    endtask

    task automatic t_reset;
        rd(IDX_CTL, 8'h00);
        rd(IDX_BLINK, 8'h00);
        rd(IDX_TCW, 8'h07);
        rd(IDX_TCH, 8'h00);
        rd(IDX_GCX_LO, 8'h00);
        rd(IDX_COLB, 8'h00);
        chk(text_cursor_w_px, 32'h8);
        chk(text_cursor_h_px, 32'h1);
        wr(8'h46, 8'hA5);
        rd(8'h46, 8'h00);
        $display("done reset values");
    endtask

    task automatic t_shadow;
        wr(IDX_TOPY_LO, 8'hFF);
        rd(IDX_TOPY_LO, 8'h00);
        chk(overlay1.top_y, 32'h0);
        wr(IDX_TOPY_HI, 8'hFF);
        nap;
        chk(overlay1.top_y, 32'h1FFC);
        rd(IDX_TOPY_HI, 8'h1F);
        rd(IDX_TOPY_LO, 8'hFC);
        $display("done shadow commit");
    endtask

    task automatic t_select;
        @(posedge clock);
        overlay_select <= 1'b1;
        wr(IDX_WID_LO, 8'hFF);
        wr(IDX_WID_HI, 8'hFF);
        wr(IDX_HGT_LO, 8'h0D);
        wr(IDX_HGT_HI, 8'hDF);
        nap;
        chk(overlay2.width, 32'h3FF8);
        chk(overlay2.height, 32'h1F0C);
        chk(overlay1.width, 32'h0);
        rd(IDX_WID_HI, 8'h3F);
        @(posedge clock);
        overlay_select <= 1'b0;
        rd(IDX_WID_HI, 8'h00);
        $display("done window select");
    endtask

    task automatic t_cursor;
        for (int k = 0; k < 4; k++)
        begin
            wr(IDX_CTL, 8'(8'h10 | (k << 2)));
            nap;
            chk(cursor_shape_set, 32'(k));
            chk(graphic_cursor_on, 32'h1);
        end
        @(posedge clock);
        vertical_scan_reverse <= 1'b1;
        nap;
        chk(graphic_cursor_on, 32'h0);
        @(posedge clock);
        vertical_scan_reverse <= 1'b0;
        wr(IDX_CTL, 8'h12);
        nap;
        chk({graphic_cursor_on, text_cursor_on}, 32'h2);
        wr(IDX_CTL, 8'h02);
        nap;
        chk({graphic_cursor_on, text_cursor_on}, 32'h1);
        $display("done cursor control");
    endtask

    task automatic t_blink;
        wr(IDX_BLINK, 8'h01);
        wr(IDX_CTL, 8'h03);
        nap;
        chk(text_cursor_on, 32'h1);
        frame;
        chk(text_cursor_on, 32'h1);
        frame;
        chk(text_cursor_on, 32'h0);
        frame;
        chk(text_cursor_on, 32'h0);
        frame;
        chk(text_cursor_on, 32'h1);
        frame;
        frame;
        chk(text_cursor_on, 32'h0);
        wr(IDX_CTL, 8'h02);
        frame;
        chk(text_cursor_on, 32'h1);
        $display("done blink");
    endtask

    task automatic t_size_pos;
        wr(IDX_TCW, 8'hFF);
        rd(IDX_TCW, 8'h1F);
        wr(IDX_TCH, 8'hE4);
        rd(IDX_TCH, 8'h04);
        @(posedge clock);
        char_scale_x <= 2'h1;
        char_scale_y <= 2'h3;
        nap;
        chk(text_cursor_w_px, 32'h40);
        chk(text_cursor_h_px, 32'h14);
        wr(IDX_GCX_LO, 8'h34);
        wr(IDX_GCX_HI, 8'hFF);
        wr(IDX_GCY_LO, 8'hAB);
        wr(IDX_GCY_HI, 8'hE5);
        wr(IDX_COLA, 8'hE3);
        wr(IDX_COLB, 8'h1C);
        nap;
        chk(graphic_cursor_x, 32'h1F34);
        chk(graphic_cursor_y, 32'h05AB);
        rd(IDX_GCY_HI, 8'h05);
        chk({cursor_color_a.red, cursor_color_a.blue}, 32'h1F);
        chk(cursor_color_b.green, 32'h7);
        $display("done sizes and positions");
    endtask

    task automatic pix(input logic [31:0] e);
        @(posedge clock);
        pixel_in       <= 24'h050505;
        pixel_in_valid <= 1'b1;
        @(posedge clock);
        pixel_in_valid <= 1'b0;
        @(negedge clock);
        chk({pixel_out_valid, pixel_out}, e);
    endtask

    task automatic t_gamma;
        for (int k = 0; k < 4; k++)
        begin
            wr(IDX_CTL, 8'(k << 5));
            @(posedge clock);
            gamma_wr      <= 1'b1;
            gamma_wr_addr <= 8'h05;
            gamma_wr_data <= 8'(8'h10 + k);
            @(posedge clock);
            gamma_wr <= 1'b0;
        end
        wr(IDX_CTL, 8'h80);
        nap;
        chk(gamma_enable, 32'h1);
        pix(32'h01121110);
        wr(IDX_CTL, 8'h00);
        pix(32'h01050505);
        $display("done gamma");
    endtask

    initial
    begin
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        t_reset;
        t_shadow;
        t_select;
        t_cursor;
        t_blink;
        t_size_pos;
        t_gamma;
        close_out;
    end

    initial
    begin
        repeat (20000) @(posedge clock);
        failures++;
        close_out;
    end
endmodule // tb_overlay_cursor_config_regs
